/* File: inc/sbc_defines.vh */
// register offsets, field positions, mode codes, reset values, page limit and wait counter width
`ifndef SBC_DEFINES_VH
`define SBC_DEFINES_VH
`define SBC_ADDR_BUS_CS      16'hff00
`define SBC_ADDR_STACK_PAGE  16'hff01
`define SBC_ADDR_WAIT_CLK    16'hff02
`define SBC_BUS_MODE_HI      7
`define SBC_BUS_MODE_LO      6
`define SBC_CS_SIZE_HI       5
`define SBC_CS_SIZE_LO       4
`define SBC_RELEASE_BIT      7
`define SBC_WAIT_HI          6
`define SBC_WAIT_LO          4
`define SBC_CLK_SRC_BIT      3
`define SBC_HS_OSC_BIT       2
`define SBC_VDC_HI           1
`define SBC_VDC_LO           0
`define SBC_MODE_SINGLE      2'h0
`define SBC_MODE_64K         2'h1
`define SBC_MODE_512K_MIN    2'h2
`define SBC_MODE_512K_MAX    2'h3
`define SBC_RST_CS_INT       8'h30
`define SBC_RST_CS_EXT_LOW   6'h31
`define SBC_RST_PAGE         8'h00
`define SBC_RST_WAIT_CLK     8'h00
`define SBC_PAGE_MAX         8'h27
`define SBC_WAIT_CNT_W       4
`endif

/* File: src/sbc_wait_gen.v */
// wait-state counter for external accesses
`timescale 1ns/1ps
module sbc_wait_gen (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire [2:0] wait_code_i,
  input  wire       ext_start_i,
  output reg        ext_busy_o
);
  `include "sbc_defines.vh"
  reg [`SBC_WAIT_CNT_W-1:0] cnt;
  // 3-bit code maps to 2 states per step
  wire [`SBC_WAIT_CNT_W-1:0] load = {wait_code_i, 1'b0};
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt        <= 4'h0;
      ext_busy_o <= 1'b0;
    end else if (ext_start_i && !ext_busy_o && load != 4'h0) begin
      cnt        <= load - 4'h1;
      ext_busy_o <= 1'b1;
    end else if (ext_busy_o) begin
      if (cnt == 4'h0) begin
        ext_busy_o <= 1'b0;
      end else begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule

/* File: src/sbc_regs.v */
// system controller and bus control register bank with wishbone slave
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
module sbc_regs #(
  parameter       EXT_PROGRAM  = 1'b0,
  parameter [1:0] EXT_BUS_MODE = 2'h1
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [15:0] adr_i,
  input  wire [7:0]  dat_i,
  input  wire        sel_i,
  output reg  [7:0]  dat_o,
  output reg         ack_o,
  input  wire [3:0]  port_data_i,
  input  wire [3:0]  port_hiz_i,
  input  wire [18:0] ext_addr_i,
  input  wire        ext_start_i,
  input  wire        shared_input_pin_request_i,
  input  wire        bus_grant_req_i,
  input  wire        port_grant_pin_data_i,
  output reg  [3:0]  chip_select_port_pins_o,
  output reg  [3:0]  chip_select_port_pins_oe_n_o,
  output reg         shared_output_pin_grant_o,
  output reg         bus_request_o,
  output reg         port_request_pin_o,
  output reg         irq_enable_o,
  output reg  [1:0]  bus_mode_o,
  output reg  [7:0]  stack_page_o,
  output reg         cpu_clock_source_select_o,
  output reg         high_speed_oscillator_on_o,
  output reg  [1:0]  core_voltage_mode_o,
  output reg         ext_busy_o
);
  `include "sbc_defines.vh"
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [7:0] clamp_page;
    input [1:0] mode;
    input [7:0] page;
    begin
      if (mode != `SBC_MODE_512K_MAX) begin
        clamp_page = 8'h00;
      end else if (page > `SBC_PAGE_MAX) begin
        clamp_page = `SBC_PAGE_MAX;
      end else begin
        clamp_page = page;
      end
    end
  endfunction
  // select active for address in an area, given mode and size
  function cs_hit;
    input [1:0]  mode;
    input [1:0]  size;
    input [1:0]  idx;
    input [18:0] a;
    begin
      case (mode)
        `SBC_MODE_SINGLE: cs_hit = 1'b0;
        `SBC_MODE_64K: begin
          case (size)
            2'h3:    cs_hit = (idx == 2'h0);
            2'h2:    cs_hit = (a[15] == idx[0]) && !idx[1];
            2'h1:    cs_hit = (a[15:14] == idx);
            default: cs_hit = (a[14:13] == idx);
          endcase
        end
        default: cs_hit = (a[18:17] == idx);
      endcase
    end
  endfunction
  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // one-hot hit: bit 0 mode/select, bit 1 stack page, bit 2 wait/clock
  // unmapped addresses read zero and ignore writes
  function [2:0] reg_hit;
    input [15:0] a;
    begin
      case (a)
        `SBC_ADDR_BUS_CS:     reg_hit = 3'b001;
        `SBC_ADDR_STACK_PAGE: reg_hit = 3'b010;
        `SBC_ADDR_WAIT_CLK:   reg_hit = 3'b100;
        default:              reg_hit = 3'b000;
      endcase
    end
  endfunction
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  // external program makes select 0 live from the first edge after reset release
  wire [7:0] rst_cs = EXT_PROGRAM ? {EXT_BUS_MODE, `SBC_RST_CS_EXT_LOW}
                                  : `SBC_RST_CS_INT;
  // ----------------------------------------
  // bus access
  // ----------------------------------------
  wire       acc     = cyc_i && stb_i && !ack_o;
  wire       wr      = acc && we_i && sel_i;
  wire [2:0] hit     = reg_hit(adr_i);
  wire       wr_cs   = wr && hit[0];
  wire       wr_page = wr && hit[1];
  wire       wr_wait = wr && hit[2];
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg  [7:0] bus_cs_ctl;
  reg  [7:0] page_reg;
  reg  [7:0] wait_ctl;
  reg        wrote_cs;
  reg        wrote_page;
  reg        rst_d;
  wire [1:0] mode = bus_cs_ctl[`SBC_BUS_MODE_HI:`SBC_BUS_MODE_LO];
  wire [1:0] size = bus_cs_ctl[`SBC_CS_SIZE_HI:`SBC_CS_SIZE_LO];
  wire       rel  = wait_ctl[`SBC_RELEASE_BIT];
  // mode/select: option value lands one edge after release
  always @(posedge clk_i) begin
    if (rst_i) begin
      bus_cs_ctl <= `SBC_RST_CS_INT;
      rst_d      <= 1'b1;
    end else begin
      rst_d <= 1'b0;
      if (wr_cs) begin
        bus_cs_ctl <= dat_i;
      end else if (rst_d) begin
        bus_cs_ctl <= rst_cs;
      end
    end
  end
  // ----------------------------------------
  // stack page
  // ----------------------------------------
  // clamped against the mode in force at write time, not re-clamped later
  always @(posedge clk_i) begin
    if (rst_i) begin
      page_reg <= `SBC_RST_PAGE;
    end else if (wr_page) begin
      page_reg <= clamp_page(mode, dat_i);
    end
  end
  // ----------------------------------------
  // wait, clock and power
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      wait_ctl <= `SBC_RST_WAIT_CLK;
    end else if (wr_wait) begin
      wait_ctl <= dat_i;
    end
  end
  // ----------------------------------------
  // first-write tracking
  // ----------------------------------------
  // sticky until reset; any value counts as a write
  always @(posedge clk_i) begin
    if (rst_i) begin
      wrote_cs   <= 1'b0;
      wrote_page <= 1'b0;
    end else begin
      if (wr_cs) begin
        wrote_cs <= 1'b1;
      end
      if (wr_page) begin
        wrote_page <= 1'b1;
      end
    end
  end
  // ----------------------------------------
  // wishbone answer
  // ----------------------------------------
  // one-cycle ack; the next request is only taken after it drops
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 8'h00;
    end else begin
      ack_o <= acc;
      case (hit)
        3'b001:  dat_o <= bus_cs_ctl;
        3'b010:  dat_o <= page_reg;
        3'b100:  dat_o <= wait_ctl;
        default: dat_o <= 8'h00;
      endcase
    end
  end
  // ----------------------------------------
  // chip-select pins
  // ----------------------------------------
  // an enabled select owns its pin whatever the port or its float control says
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_cs
      localparam [1:0] IDX = i;
      // single chip keeps the pins as dc port outputs
      wire cs_on  = bus_cs_ctl[i] && (mode != `SBC_MODE_SINGLE);
      wire cs_sel = ext_start_i && cs_hit(mode, size, IDX, ext_addr_i);
      always @(posedge clk_i) begin
        if (rst_i) begin
          chip_select_port_pins_o[i]      <= 1'b1;
          chip_select_port_pins_oe_n_o[i] <= 1'b1;
        end else if (cs_on) begin
          // active-low select, hiz control ignored
          chip_select_port_pins_o[i]      <= !cs_sel;
          chip_select_port_pins_oe_n_o[i] <= 1'b0;
        end else begin
          chip_select_port_pins_o[i]      <= port_data_i[i];
          chip_select_port_pins_oe_n_o[i] <= port_hiz_i[i];
        end
      end
    end
  endgenerate
  // ----------------------------------------
  // bus release pins
  // ----------------------------------------
  // grant pin is active low when used as bus grant
  always @(posedge clk_i) begin
    if (rst_i) begin
      shared_output_pin_grant_o <= 1'b0;
      bus_request_o             <= 1'b0;
      port_request_pin_o        <= 1'b0;
    end else if (rel) begin
      shared_output_pin_grant_o <= !bus_grant_req_i;
      bus_request_o             <= !shared_input_pin_request_i;
      port_request_pin_o        <= 1'b1;
    end else begin
      shared_output_pin_grant_o <= port_grant_pin_data_i;
      bus_request_o             <= 1'b0;
      port_request_pin_o        <= shared_input_pin_request_i;
    end
  end
  // ----------------------------------------
  // interrupt hold-off
  // ----------------------------------------
  // even the non-maskable source waits for both first writes
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_enable_o <= 1'b0;
    end else begin
      irq_enable_o <= wrote_cs && wrote_page;
    end
  end
  // ----------------------------------------
  // control copies
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      bus_mode_o   <= 2'h0;
      stack_page_o <= 8'h00;
    end else begin
      bus_mode_o   <= mode;
      stack_page_o <= page_reg;
    end
  end
  // ----------------------------------------
  // clock and supply settings
  // ----------------------------------------
  // only passed on; switching the clock or supply is done outside
  always @(posedge clk_i) begin
    if (rst_i) begin
      cpu_clock_source_select_o  <= 1'b0;
      high_speed_oscillator_on_o <= 1'b0;
      core_voltage_mode_o        <= 2'h0;
    end else begin
      cpu_clock_source_select_o  <= wait_ctl[`SBC_CLK_SRC_BIT];
      high_speed_oscillator_on_o <= wait_ctl[`SBC_HS_OSC_BIT];
      core_voltage_mode_o        <= wait_ctl[`SBC_VDC_HI:`SBC_VDC_LO];
    end
  end
  // ----------------------------------------
  // wait states
  // ----------------------------------------
  // single chip has no external access, so no wait states
  wire busy;
  wire ext_go = ext_start_i && (mode != `SBC_MODE_SINGLE);
  sbc_wait_gen u_wait (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .wait_code_i (wait_ctl[`SBC_WAIT_HI:`SBC_WAIT_LO]),
    .ext_start_i (ext_go),
    .ext_busy_o  (busy)
  );
  always @(posedge clk_i) begin
    if (rst_i) begin
      ext_busy_o <= 1'b0;
    end else begin
      ext_busy_o <= busy;
    end
  end
endmodule

/* File: sim/sbc_regs_properties.sv */
// assertions on the register bank ports
`timescale 1ns/1ps
module sbc_regs_properties (
  input logic        clk_i,
  input logic        rst_i,
  input logic        cyc_i,
  input logic        stb_i,
  input logic        we_i,
  input logic [15:0] adr_i,
  input logic        sel_i,
  input logic        ack_o,
  input logic [3:0]  port_hiz_i,
  input logic        ext_start_i,
  input logic        shared_input_pin_request_i,
  input logic        bus_grant_req_i,
  input logic [3:0]  chip_select_port_pins_oe_n_o,
  input logic        shared_output_pin_grant_o,
  input logic        bus_request_o,
  input logic        irq_enable_o,
  input logic [1:0]  bus_mode_o,
  input logic [7:0]  stack_page_o,
  input logic        ext_busy_o
);
  // ----
  // checks
  // ----
  wire wr = cyc_i & stb_i & we_i & sel_i & ~ack_o;
  reg  s0;
  reg  s1;
  // flags set at the taking edge, the same edge that stores the write, one cycle ahead of irq_enable_o
  always @(posedge clk_i) begin
    s0 <= !rst_i && (s0 || wr && adr_i == 16'hff00);
    s1 <= !rst_i && (s1 || wr && adr_i == 16'hff01);
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("ack not one cycle");
  a_irq_held: assert property (!(s0 && s1) |-> !irq_enable_o)
    else $error("irq enabled early");
  a_irq_rise: assert property ($rose(s0 && s1) |-> ##[1:2] irq_enable_o)
    else $error("irq not enabled");
  a_page_max: assert property (stack_page_o <= 8'h27)
    else $error("page above limit");
  a_page_mode: assert property ($changed(stack_page_o) |-> !stack_page_o || $past(bus_mode_o) == 2'h3)
    else $error("page outside max mode");
  a_single_port: assert property (!$past(rst_i) && bus_mode_o == 2'h0 && $past(bus_mode_o, 2) == 2'h0
    |-> chip_select_port_pins_oe_n_o == $past(port_hiz_i))
    else $error("single chip pin enable");
  a_grant_pin: assert property (bus_request_o |-> shared_output_pin_grant_o == !$past(bus_grant_req_i))
    else $error("grant pin wrong");
  a_request_pin: assert property (bus_request_o |-> !$past(shared_input_pin_request_i))
    else $error("request without pin");
  a_wait_start: assert property ($rose(ext_busy_o) |-> $past(ext_start_i, 2))
    else $error("wait start wrong");
  cover property (irq_enable_o);
  cover property (bus_request_o && !shared_output_pin_grant_o);
  cover property ($rose(ext_busy_o));
endmodule
bind sbc_regs sbc_regs_properties chk_u (.*);

/* File: sim/sbc_bus_peer.sv */
// external bus requester on the release pins
`timescale 1ns/1ps
module sbc_bus_peer (
  input  wire logic clk_i,
  input  wire logic want_i,
  input  wire logic grant_n_i,
  output logic      req_n_o,
  output logic      granted_o
);
  // request pin idles high as if pulled up
  initial req_n_o = 1'b1;
  initial granted_o = 1'b0;
  always @(posedge clk_i) begin
    req_n_o <= ~want_i;
    granted_o <= ~req_n_o & ~grant_n_i;
  end
endmodule

/* File: sim/test_system_bus_controller_regs.sv */
// self-checking bench for the system bus controller registers
`timescale 1ns/1ps
module test_system_bus_controller_regs;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i, stb_i, we_i, sel_i, ext_start_i, bus_grant_req_i, port_grant_pin_data_i;
  logic        ack_o, shared_input_pin_request_i, shared_output_pin_grant_o, bus_request_o;
  logic        port_request_pin_o, irq_enable_o, cpu_clock_source_select_o;
  logic        high_speed_oscillator_on_o;
  logic        ext_busy_o, want, granted;
  logic [15:0] adr_i;
  logic [7:0]  dat_i, dat_o, stack_page_o, q;
  logic [3:0]  port_data_i, port_hiz_i, chip_select_port_pins_o, chip_select_port_pins_oe_n_o;
  logic [18:0] ext_addr_i = '0;
  logic [1:0]  bus_mode_o, core_voltage_mode_o;
  integer      miscompares = 0, compares = 0, i, n;
  // address, write data, read back, bus mode after
  logic [33:0] rows [0:7] = '{{16'hff01, 8'h27, 8'h00, 2'h0}, {16'hff00, 8'hbf, 8'hbf, 2'h2},
    {16'hff00, 8'h7f, 8'h7f, 2'h1}, {16'hff00, 8'hff, 8'hff, 2'h3}, {16'hff01, 8'h27, 8'h27, 2'h3},
    {16'hff01, 8'h28, 8'h27, 2'h3}, {16'hff02, 8'h40, 8'h40, 2'h3}, {16'hff03, 8'h55, 8'h00, 2'h3}};
  sbc_regs dut_u (.*);
  sbc_bus_peer peer_u (.clk_i(clk_i), .want_i(want), .grant_n_i(shared_output_pin_grant_o),
    .req_n_o(shared_input_pin_request_i), .granted_o(granted));
  always #2 clk_i = ~clk_i;
  // ----
  // tasks
  // ----
  task chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      $display("unexpected at %0t got %h exp %h", $time, g, e);
      miscompares++;
    end
  endtask
  task wb(input logic [15:0] a, input logic [7:0] d, input logic w);
    integer k;
    k = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    do begin @(posedge clk_i); k++; end while (ack_o !== 1'b1 && k < 50);
    q = dat_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
    if (k >= 50) miscompares++;
  endtask
  task end_of_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #20000;
    miscompares++;
    end_of_test;
  end
  initial begin
    {cyc_i, stb_i, we_i, ext_start_i, bus_grant_req_i, want, adr_i, dat_i} = '0;
    {sel_i, port_grant_pin_data_i} = 2'b11;
    port_data_i = 4'hf;
    port_hiz_i = 4'hf;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 3; i++) begin
      wb(16'hff00 + i[15:0], 8'h00, 1'b0);
      chk(q, i ? 8'h00 : 8'h30);
    end
    wb(16'hff00, 8'h30, 1'b1);
    chk({7'h0, irq_enable_o}, 8'h00);
    for (i = 0; i < 8; i++) begin
      wb(rows[i][33:18], rows[i][17:10], 1'b1);
      wb(rows[i][33:18], 8'h00, 1'b0);
      chk(q, rows[i][9:2]);
      chk({6'h0, bus_mode_o}, {6'h0, rows[i][1:0]});
    end
    chk({7'h0, irq_enable_o}, 8'h01);
    chk({4'h0, chip_select_port_pins_oe_n_o}, 8'h00);
    ext_start_i <= 1'b1;
    @(posedge clk_i);
    ext_start_i <= 1'b0;
    @(posedge clk_i);
    chk({4'h0, chip_select_port_pins_o}, 8'h0e);
    n = 0;
    repeat (24) begin @(posedge clk_i); if (ext_busy_o === 1'b1) n++; end
    chk(n[7:0], 8'h08);
    wb(16'hff02, 8'h80, 1'b1);
    want <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk({7'h0, bus_request_o}, 8'h01);
    chk({7'h0, port_request_pin_o}, 8'h01);
    bus_grant_req_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk({7'h0, granted}, 8'h01);
    wb(16'hff02, 8'h0f, 1'b1);
    repeat (3) @(posedge clk_i);
    chk({6'h0, bus_request_o, shared_output_pin_grant_o}, 8'h01);
    chk({7'h0, port_request_pin_o}, 8'h00);
    chk({4'h0, cpu_clock_source_select_o, high_speed_oscillator_on_o, core_voltage_mode_o}, 8'h0f);
    end_of_test;
  end
endmodule
